// ---- pkg/serl_defines.svh ----
// Constants shared by both ends of the serial EEPROM read link.
// Assumes a 200 MHz system clock at each end.
`ifndef SERL_DEFINES_SVH
`define SERL_DEFINES_SVH

// Bus address carried in the control byte (arbitrary value)
`define SERL_DEV_ADDR 7'h50
// Position of the direction bit in the control byte
`define SERL_RW_BIT 0
// Memory array
`define SERL_MEM_DEPTH 128
`define SERL_PTR_W 7
`define SERL_DATA_W 8
// Bits per byte slot: eight data plus acknowledge
`define SERL_LAST_BIT 4'h8
// Timing
`define SERL_SYS_MHZ 200
`define SERL_QTR_NS 500
`define SERL_QTR_CYC ((`SERL_QTR_NS * `SERL_SYS_MHZ) / 1000)
`define SERL_QCNT_W 7
// Read buffer
`define SERL_FIFO_DEPTH 16

`endif

// ---- pkg/serl_pkg.sv ----
// Types shared by both ends of the serial EEPROM read link.
// Assumes serl_defines.svh is compiled alongside.
package serl_pkg;

	typedef enum logic [8:0] {
		DS_IDLE      = 9'b000000001,
		DS_CTRL      = 9'b000000010,
		DS_CTRL_ACK  = 9'b000000100,
		DS_ADDR      = 9'b000001000,
		DS_ADDR_ACK  = 9'b000010000,
		DS_WDATA     = 9'b000100000,
		DS_WDATA_ACK = 9'b001000000,
		DS_RDATA     = 9'b010000000,
		DS_RACK      = 9'b100000000
	} serl_dev_state_t;

	typedef enum logic [7:0] {
		HS_IDLE    = 8'b00000001,
		HS_START   = 8'b00000010,
		HS_CTRLW   = 8'b00000100,
		HS_ADDR    = 8'b00001000,
		HS_RESTART = 8'b00010000,
		HS_CTRLR   = 8'b00100000,
		HS_READ    = 8'b01000000,
		HS_STOP    = 8'b10000000
	} serl_host_state_t;

endpackage : serl_pkg

// ---- pkg/serl_if.sv ----
// Two-wire link between the master end and the EEPROM end.
// Both lines are open drain; the wire levels are resolved here.
`timescale 1ns/1ps
`default_nettype none

interface serl_if;
	logic hostSclOut;
	logic hostSclOe;
	logic hostSdaOut;
	logic hostSdaOe;
	logic devSdaOut;
	logic devSdaOe;
	logic sclLine;
	logic sdaLine;

	// Pulled up unless some end drives low
	assign sclLine = ~(hostSclOe & ~hostSclOut);
	assign sdaLine = ~((hostSdaOe & ~hostSdaOut) | (devSdaOe & ~devSdaOut));

	modport host (output hostSclOut, output hostSclOe, output hostSdaOut, output hostSdaOe,
		input sclLine, input sdaLine);
	modport dev (output devSdaOut, output devSdaOe, input sclLine, input sdaLine);

endinterface : serl_if

`default_nettype wire

// ---- src/serl_device.sv ----
// EEPROM end of the two-wire link: addressing, reads and the pointer.
// Assumes the link lines arrive asynchronously and that the master makes SCL.
`timescale 1ns/1ps
`default_nettype none
`include "serl_defines.svh"

// Contract
// - Master loads address via aborted write opening
// - Restart after address keeps pointer, stores nothing
// - Read control byte acknowledged, byte shifted out
// - Unacknowledged byte then stop releases data
// - Master acknowledge fetches next consecutive byte
// - Pointer advances after each completed byte
// - One sequential read covers whole array
// - Low supply blocks array writes
// - Current address read returns next location
module serl_device (
	// System
	input wire logic sys_clk,
	input wire logic rst_n,
	// Link
	serl_if.dev bus,
	// Supply monitor
	input wire logic lowSupply,
	// Status
	output logic writeBlocked
);

	serl_pkg::serl_dev_state_t stateQ;
	logic sclM, sclS, sclD;
	logic sdaM, sdaS, sdaD;
	logic lowM, lowS;
	logic [3:0] bitCntQ;
	logic [`SERL_DATA_W-1:0] shiftQ;
	logic [`SERL_PTR_W-1:0] ptrQ;
	logic sdaOeQ;
	logic sdaOutQ;
	logic ackedQ;
	logic writeBlockedQ;
	logic [`SERL_DATA_W-1:0] mem [`SERL_MEM_DEPTH];
	logic [`SERL_DATA_W-1:0] memRd;
	logic sclRise, sclFall, startSeen, stopSeen, byteDone, memWe;

	assign bus.devSdaOe = sdaOeQ;
	assign bus.devSdaOut = sdaOutQ;
	assign writeBlocked = writeBlockedQ;

	// Line and supply synchronisers
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			sclM <= 1'b1;
			sclS <= 1'b1;
			sclD <= 1'b1;
			sdaM <= 1'b1;
			sdaS <= 1'b1;
			sdaD <= 1'b1;
			lowM <= 1'b0;
			lowS <= 1'b0;
		end else begin
			sclM <= bus.sclLine;
			sclS <= sclM;
			sclD <= sclS;
			sdaM <= bus.sdaLine;
			sdaS <= sdaM;
			sdaD <= sdaS;
			lowM <= lowSupply;
			lowS <= lowM;
		end
	end

	assign sclRise = sclS & ~sclD;
	assign sclFall = ~sclS & sclD;
	assign startSeen = sclS & sclD & sdaD & ~sdaS;
	assign stopSeen = sclS & sclD & ~sdaD & sdaS;
	assign byteDone = sclFall & (bitCntQ == `SERL_LAST_BIT);
	assign memRd = mem[ptrQ];
	// Stored byte only when supply is good
	assign memWe = (stateQ == serl_pkg::DS_WDATA) & byteDone & ~lowS;

	// Supply status
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			writeBlockedQ <= 1'b0;
		end else begin
			writeBlockedQ <= lowS;
		end
	end

	// Open-drain data level, only the enable ever moves
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			sdaOutQ <= 1'b0;
		end else begin
			sdaOutQ <= 1'b0;
		end
	end

	// Array write port
	always_ff @(posedge sys_clk) begin
		if (memWe) begin
			mem[ptrQ] <= shiftQ;
		end
	end

	// Master acknowledge sampled in the ninth clock of a read byte
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			ackedQ <= 1'b0;
		end else if (stateQ == serl_pkg::DS_RACK && sclRise) begin
			ackedQ <= ~sdaS;
		end
	end

	// Protocol engine
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			stateQ <= serl_pkg::DS_IDLE;
			bitCntQ <= 4'h0;
			shiftQ <= 8'h00;
			ptrQ <= 7'h00;
			sdaOeQ <= 1'b0;
		end else if (startSeen) begin
			// Start or restart abandons any write without storing
			stateQ <= serl_pkg::DS_CTRL;
			bitCntQ <= 4'h0;
			sdaOeQ <= 1'b0;
		end else if (stopSeen) begin
			stateQ <= serl_pkg::DS_IDLE;
			bitCntQ <= 4'h0;
			sdaOeQ <= 1'b0;
		end else begin
			unique case (stateQ)
				serl_pkg::DS_IDLE: begin
					sdaOeQ <= 1'b0;
				end
				serl_pkg::DS_CTRL, serl_pkg::DS_ADDR, serl_pkg::DS_WDATA: begin
					if (sclRise && bitCntQ != `SERL_LAST_BIT) begin
						shiftQ <= {shiftQ[6:0], sdaS};
						bitCntQ <= bitCntQ + 4'h1;
					end else if (byteDone) begin
						if (stateQ == serl_pkg::DS_CTRL) begin
							if (shiftQ[7:1] == `SERL_DEV_ADDR) begin
								sdaOeQ <= 1'b1;
								stateQ <= serl_pkg::DS_CTRL_ACK;
							end else begin
								stateQ <= serl_pkg::DS_IDLE;
							end
						end else if (stateQ == serl_pkg::DS_ADDR) begin
							// Word address loaded by the write opening
							ptrQ <= shiftQ[`SERL_PTR_W-1:0];
							sdaOeQ <= 1'b1;
							stateQ <= serl_pkg::DS_ADDR_ACK;
						end else begin
							// Natural 7-bit wrap takes the top back to zero
							ptrQ <= ptrQ + 7'h01;
							sdaOeQ <= 1'b1;
							stateQ <= serl_pkg::DS_WDATA_ACK;
						end
					end
				end
				serl_pkg::DS_CTRL_ACK: begin
					if (sclFall) begin
						bitCntQ <= 4'h0;
						if (shiftQ[`SERL_RW_BIT]) begin
							// Current or random read starts at the pointer
							shiftQ <= memRd;
							sdaOeQ <= ~memRd[7];
							stateQ <= serl_pkg::DS_RDATA;
						end else begin
							sdaOeQ <= 1'b0;
							stateQ <= serl_pkg::DS_ADDR;
						end
					end
				end
				serl_pkg::DS_ADDR_ACK, serl_pkg::DS_WDATA_ACK: begin
					if (sclFall) begin
						bitCntQ <= 4'h0;
						sdaOeQ <= 1'b0;
						stateQ <= serl_pkg::DS_WDATA;
					end
				end
				serl_pkg::DS_RDATA: begin
					if (sclFall) begin
						if (bitCntQ == 4'h7) begin
							// Eighth bit out: byte complete
							sdaOeQ <= 1'b0;
							ptrQ <= ptrQ + 7'h01;
							bitCntQ <= 4'h0;
							stateQ <= serl_pkg::DS_RACK;
						end else begin
							shiftQ <= {shiftQ[6:0], 1'b0};
							sdaOeQ <= ~shiftQ[6];
							bitCntQ <= bitCntQ + 4'h1;
						end
					end
				end
				serl_pkg::DS_RACK: begin
					if (sclFall) begin
						if (ackedQ) begin
							shiftQ <= memRd;
							sdaOeQ <= ~memRd[7];
							stateQ <= serl_pkg::DS_RDATA;
						end else begin
							// No acknowledge: keep the bus released
							sdaOeQ <= 1'b0;
							stateQ <= serl_pkg::DS_IDLE;
						end
					end
				end
			endcase
		end
	end

endmodule : serl_device

`default_nettype wire

// ---- src/serl_host.sv ----
// Master end of the two-wire link plus its read-data buffer.
// Assumes the EEPROM end holds SCL released and answers within each bit slot.
`timescale 1ns/1ps
`default_nettype none
`include "serl_defines.svh"

module serl_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = `SERL_FIFO_DEPTH
) (
	// System
	input wire logic sys_clk,
	input wire logic rst_n,
	// Fill side
	input wire logic inValid,
	output logic inReady,
	input wire logic [WIDTH-1:0] inData,
	// Drain side
	output logic outValid,
	input wire logic outReady,
	output logic [WIDTH-1:0] outData
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wrPtrQ, rdPtrQ;
	logic [AW:0] countQ;
	logic push, pop;

	assign inReady = countQ != (AW + 1)'(DEPTH);
	assign outValid = countQ != '0;
	assign outData = mem[rdPtrQ];
	assign push = inValid & inReady;
	assign pop = outValid & outReady;

	always_ff @(posedge sys_clk) begin
		if (push) begin
			mem[wrPtrQ] <= inData;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			wrPtrQ <= '0;
			rdPtrQ <= '0;
			countQ <= '0;
		end else begin
			wrPtrQ <= wrPtrQ + AW'(push);
			rdPtrQ <= rdPtrQ + AW'(pop);
			countQ <= countQ + (AW + 1)'(push) - (AW + 1)'(pop);
		end
	end
endmodule : serl_fifo

module serl_host (
	// System
	input wire logic sys_clk,
	input wire logic rst_n,
	// Link
	serl_if.host bus,
	// Read request
	input wire logic reqValid,
	output logic reqReady,
	input wire logic reqRandom,
	input wire logic [`SERL_PTR_W-1:0] reqAddr,
	input wire logic [7:0] reqCount,
	// Read data
	output logic rdValid,
	input wire logic rdReady,
	output logic [`SERL_DATA_W-1:0] rdData,
	// Status
	output logic nackErr
);
	localparam logic [`SERL_QCNT_W-1:0] QMAX = `SERL_QCNT_W'(`SERL_QTR_CYC - 1);

	serl_pkg::serl_host_state_t stateQ;
	logic [`SERL_QCNT_W-1:0] qtrQ;
	logic [1:0] phaseQ;
	logic [3:0] bitQ;
	logic [7:0] txQ, rxQ, leftQ;
	logic [`SERL_PTR_W-1:0] addrQ;
	logic randomQ, nackQ, sclLowQ, sdaLowQ, reqReadyQ, nackErrQ, zeroQ;
	logic sdaM, sdaS;
	logic fifoReady, hold, step, push, lastBit, idle;

	assign bus.hostSclOe = sclLowQ;
	assign bus.hostSdaOe = sdaLowQ;
	assign bus.hostSclOut = zeroQ;
	assign bus.hostSdaOut = zeroQ;
	assign reqReady = reqReadyQ;
	assign nackErr = nackErrQ;

	assign idle = stateQ == serl_pkg::HS_IDLE;
	assign lastBit = bitQ == `SERL_LAST_BIT;
	// Full buffer stretches SCL low before the acknowledge
	assign hold = stateQ == serl_pkg::HS_READ && lastBit && phaseQ == 2'd1 && !fifoReady;
	assign step = !idle && qtrQ == QMAX && !hold;
	assign push = step && stateQ == serl_pkg::HS_READ && lastBit && phaseQ == 2'd1;

	serl_fifo #(.WIDTH(`SERL_DATA_W), .DEPTH(`SERL_FIFO_DEPTH)) u_serl_fifo (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.inValid(push),
		.inReady(fifoReady),
		.inData(rxQ),
		.outValid(rdValid),
		.outReady(rdReady),
		.outData(rdData)
	);

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			sdaM <= 1'b1;
			sdaS <= 1'b1;
			zeroQ <= 1'b0;
		end else begin
			sdaM <= bus.sdaLine;
			sdaS <= sdaM;
			zeroQ <= 1'b0;
		end
	end

	// Quarter-bit divider
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			qtrQ <= '0;
		end else if (idle) begin
			qtrQ <= '0;
		end else if (qtrQ != QMAX) begin
			qtrQ <= qtrQ + `SERL_QCNT_W'(1);
		end else if (!hold) begin
			qtrQ <= '0;
		end
	end

	// Sequencer
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			stateQ <= serl_pkg::HS_IDLE;
			phaseQ <= 2'd0;
			bitQ <= 4'h0;
			txQ <= 8'h00;
			rxQ <= 8'h00;
			leftQ <= 8'h00;
			addrQ <= '0;
			randomQ <= 1'b0;
			nackQ <= 1'b0;
			sclLowQ <= 1'b0;
			sdaLowQ <= 1'b0;
			reqReadyQ <= 1'b1;
			nackErrQ <= 1'b0;
		end else if (idle) begin
			if (reqValid && reqReadyQ) begin
				reqReadyQ <= 1'b0;
				nackErrQ <= 1'b0;
				randomQ <= reqRandom;
				addrQ <= reqAddr;
				leftQ <= reqCount;
				phaseQ <= 2'd0;
				bitQ <= 4'h0;
				stateQ <= serl_pkg::HS_START;
			end
		end else if (step) begin
			phaseQ <= phaseQ + 2'd1;
			unique case (phaseQ)
				2'd0: begin
					sclLowQ <= 1'b1;
					if (stateQ == serl_pkg::HS_START || stateQ == serl_pkg::HS_RESTART) begin
						sdaLowQ <= 1'b0;
					end else if (stateQ == serl_pkg::HS_STOP) begin
						sdaLowQ <= 1'b1;
					end else if (stateQ == serl_pkg::HS_READ) begin
						// Acknowledge every byte but the last
						sdaLowQ <= lastBit && leftQ != 8'h00;
					end else begin
						sdaLowQ <= !lastBit && !txQ[7];
					end
				end
				2'd1: begin
					sclLowQ <= 1'b0;
				end
				2'd2: begin
					if (stateQ == serl_pkg::HS_START || stateQ == serl_pkg::HS_RESTART) begin
						sdaLowQ <= 1'b1;
					end else if (stateQ == serl_pkg::HS_STOP) begin
						sdaLowQ <= 1'b0;
					end else if (stateQ == serl_pkg::HS_READ) begin
						if (!lastBit) begin
							rxQ <= {rxQ[6:0], sdaS};
						end
					end else if (lastBit) begin
						nackQ <= sdaS;
					end else begin
						txQ <= {txQ[6:0], 1'b0};
					end
				end
				2'd3: begin
					unique case (stateQ)
						serl_pkg::HS_START: begin
							sclLowQ <= 1'b1;
							// Current-address read skips the address phase
							txQ <= {`SERL_DEV_ADDR, !randomQ};
							stateQ <= randomQ ? serl_pkg::HS_CTRLW : serl_pkg::HS_CTRLR;
						end
						serl_pkg::HS_RESTART: begin
							sclLowQ <= 1'b1;
							txQ <= {`SERL_DEV_ADDR, 1'b1};
							stateQ <= serl_pkg::HS_CTRLR;
						end
						serl_pkg::HS_STOP: begin
							reqReadyQ <= 1'b1;
							stateQ <= serl_pkg::HS_IDLE;
						end
						default: begin
							if (!lastBit) begin
								bitQ <= bitQ + 4'h1;
							end else begin
								bitQ <= 4'h0;
								if (stateQ != serl_pkg::HS_READ && nackQ) begin
									nackErrQ <= 1'b1;
									stateQ <= serl_pkg::HS_STOP;
								end else if (stateQ == serl_pkg::HS_CTRLW) begin
									txQ <= {1'b0, addrQ};
									stateQ <= serl_pkg::HS_ADDR;
								end else if (stateQ == serl_pkg::HS_ADDR) begin
									stateQ <= serl_pkg::HS_RESTART;
								end else if (stateQ == serl_pkg::HS_CTRLR) begin
									stateQ <= serl_pkg::HS_READ;
								end else if (leftQ == 8'h00) begin
									stateQ <= serl_pkg::HS_STOP;
								end else begin
									leftQ <= leftQ - 8'h01;
								end
							end
						end
					endcase
				end
			endcase
		end
	end

endmodule : serl_host

`default_nettype wire

// ---- testbench/serl_link_asserts.sv ----
// Checker for the main two-wire link between the master and EEPROM ends.
// Assumes plain hookup to the resolved lines, output levels and device enable of one serl_if.
`timescale 1ns/1ps
`default_nettype none

module serl_link_asserts (
	// System
	input wire logic sys_clk,
	input wire logic rst_n,
	// Link
	input wire logic hostSclOut,
	input wire logic hostSdaOut,
	input wire logic devSdaOut,
	input wire logic devSdaOe,
	input wire logic sclLine,
	input wire logic sdaLine
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	logic sclPrev_q;
	logic sdaPrev_q;
	logic rdFrame_q;
	logic [3:0] bitCnt_q;
	logic [1:0] byteIdx_q;
	wire startDet = sclLine & sclPrev_q & sdaPrev_q & ~sdaLine;
	wire stopDet = sclLine & sclPrev_q & ~sdaPrev_q & sdaLine;
	wire ninth = sclLine & ~sclPrev_q & (bitCnt_q == 4'h8);
	wire rdAck = ninth & rdFrame_q & (byteIdx_q != 2'h0);

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			sclPrev_q <= 1'b1;
			sdaPrev_q <= 1'b1;
		end else begin
			sclPrev_q <= sclLine;
			sdaPrev_q <= sdaLine;
		end
	end

	// Bit and byte position within the current frame
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			bitCnt_q <= 4'h0;
			byteIdx_q <= 2'h0;
			rdFrame_q <= 1'b0;
		end else if (startDet) begin
			bitCnt_q <= 4'h0;
			byteIdx_q <= 2'h0;
		end else if (sclLine & ~sclPrev_q) begin
			bitCnt_q <= ninth ? 4'h0 : bitCnt_q + 4'h1;
			if (ninth && byteIdx_q != 2'h3) byteIdx_q <= byteIdx_q + 2'h1;
			if (bitCnt_q == 4'h7 && byteIdx_q == 2'h0) rdFrame_q <= sdaLine;
		end
	end

	property p_ctrl_ack;
		ninth && byteIdx_q == 2'h0 |-> devSdaOe;
	endproperty
	property p_addr_ack;
		ninth && byteIdx_q == 2'h1 && !rdFrame_q |-> devSdaOe;
	endproperty
	property p_nack_release;
		rdAck && sdaLine |-> !devSdaOe throughout (##[1:800] stopDet);
	endproperty
	property p_ack_next;
		rdAck && !sdaLine |-> ##[1:1000] bitCnt_q == 4'h1;
	endproperty
	property p_stop_release;
		stopDet |=> !devSdaOe [*8];
	endproperty
	property p_start_scl;
		startDet |-> ##[1:120] !sclLine;
	endproperty
	property p_scl_low;
		$fell(sclLine) |-> !sclLine [*8];
	endproperty
	property p_od_level;
		!(hostSclOut | hostSdaOut | devSdaOut);
	endproperty
	// Device moves its data line only while the clock is low
	property p_sda_steady;
		$changed(devSdaOe) |-> !sclLine;
	endproperty

	a_ctrl_ack: assert property (p_ctrl_ack) else $error("control byte not acknowledged");
	a_addr_ack: assert property (p_addr_ack) else $error("word address not acknowledged");
	a_nack_release: assert property (p_nack_release) else $error("data held after no acknowledge");
	a_ack_next: assert property (p_ack_next) else $error("next byte missing after acknowledge");
	a_stop_release: assert property (p_stop_release) else $error("data driven after stop");
	a_start_scl: assert property (p_start_scl) else $error("clock not lowered after start");
	a_scl_low: assert property (p_scl_low) else $error("clock low phase too short");
	a_od_level: assert property (p_od_level) else $error("open drain level not low");
	a_sda_steady: assert property (p_sda_steady) else $error("data changed while clock high");

	c_read_frame: cover property (ninth && rdFrame_q && byteIdx_q == 2'h0);
	c_read_ack: cover property (rdAck && !sdaLine);
	c_stop: cover property (stopDet);
endmodule : serl_link_asserts

`default_nettype wire

// ---- testbench/serl_link_bench.sv ----
// Bench joining both ends, plus a bench-driven master on a second EEPROM end.
// Assumes the design files and serl_defines.svh are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "serl_defines.svh"

module serl_link_bench;
	logic sys_clk, rst_n, reqValid, reqRandom, rdReady, lowSupply;
	logic [6:0] reqAddr;
	logic [7:0] reqCount;
	wire reqReady, rdValid, nackErr, writeBlocked, writeBlockedB;
	int failures = 0;
	int samplesChecked = 0;
	int popCnt = 0;

	serl_if bus();
	serl_if busB();
	serl_host u_serl_host (.sys_clk, .rst_n, .bus(bus), .reqValid, .reqReady, .reqRandom, .reqAddr,
		.reqCount, .rdValid, .rdReady, .rdData(), .nackErr);
	serl_device u_serl_device (.sys_clk, .rst_n, .bus(bus), .lowSupply, .writeBlocked);
	serl_device u_serl_device_b (.sys_clk, .rst_n, .bus(busB), .lowSupply, .writeBlocked(writeBlockedB));
	serl_link_asserts u_serl_link_asserts (.sys_clk, .rst_n, .hostSclOut(bus.hostSclOut),
		.hostSdaOut(bus.hostSdaOut), .devSdaOut(bus.devSdaOut), .devSdaOe(bus.devSdaOe),
		.sclLine(bus.sclLine), .sdaLine(bus.sdaLine));

	initial begin
		sys_clk = 1'b0;
		forever #2.5 sys_clk = ~sys_clk;
	end

	always @(posedge sys_clk) if (rdValid === 1'b1 && rdReady) popCnt <= popCnt + 1;

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samplesChecked++;
		if (seen !== exp) begin
			failures++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	task automatic end_of_test();
		$display("checks=%0d mismatches=%0d", samplesChecked, failures);
		if (failures == 0 && samplesChecked > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : end_of_test

	function automatic logic [7:0] pat(input logic [6:0] l);
		return {l[0], l} ^ 8'h3c;
	endfunction : pat

	// Bench master: one quarter of a 64 ns bit per call
	task automatic lk(input logic scl, input logic sda);
		busB.hostSclOe = ~scl;
		busB.hostSdaOe = ~sda;
		#16;
	endtask : lk
	task automatic lbit(input logic b, output logic r);
		lk(1'b0, b);
		lk(1'b0, b);
		lk(1'b1, b);
		r = busB.sdaLine;
		lk(1'b1, b);
	endtask : lbit
	task automatic lstart();
		repeat (3) lk(1'b0, 1'b1);
		lk(1'b1, 1'b1);
		lk(1'b1, 1'b0);
	endtask : lstart
	task automatic lstop();
		repeat (2) lk(1'b0, 1'b0);
		lk(1'b1, 1'b0);
		lk(1'b1, 1'b1);
	endtask : lstop
	task automatic lbyte(input logic [7:0] tx, input logic ackIn, output logic [7:0] rx, output logic ackOut);
		for (int i = 7; i >= 0; i--) lbit(tx[i], rx[i]);
		lbit(ackIn, ackOut);
	endtask : lbyte
	task automatic lsend(input logic [7:0] tx);
		logic [7:0] rx;
		logic k;
		lbyte(tx, 1'b1, rx, k);
		check(k, 1'b0);
	endtask : lsend
	task automatic laddr(input logic [6:0] a);
		lstart();
		lsend({`SERL_DEV_ADDR, 1'b0});
		lsend({1'b0, a});
	endtask : laddr
	task automatic lwrite(input logic [6:0] a, input int n, input logic inv);
		laddr(a);
		for (int i = 0; i < n; i++) lsend(pat(7'(a + i)) ^ {8{inv}});
		lstop();
	endtask : lwrite
	task automatic lread(input logic rnd, input logic [6:0] a, input int n);
		logic [7:0] rx;
		logic k;
		if (rnd) laddr(a);
		lstart();
		lsend({`SERL_DEV_ADDR, 1'b1});
		for (int i = 0; i < n; i++) begin
			lbyte(8'hff, (i == n - 1), rx, k);
			check(rx, pat(7'(a + i)));
		end
		lstop();
		check(busB.devSdaOe, 1'b0);
	endtask : lread

	task automatic t_fill_read_all();
		lwrite(7'h7f, 128, 1'b0);
		lread(1'b1, 7'h05, 129);
	endtask : t_fill_read_all
	task automatic t_current_read();
		lread(1'b0, 7'h06, 1);
	endtask : t_current_read
	task automatic t_low_supply();
		@(negedge sys_clk);
		lowSupply = 1'b1;
		repeat (2) @(negedge sys_clk);
		check(writeBlocked, 1'b0);
		@(negedge sys_clk);
		check({writeBlocked, writeBlockedB}, 2'h3);
		lwrite(7'h20, 2, 1'b1);
		@(negedge sys_clk);
		lowSupply = 1'b0;
		lread(1'b1, 7'h20, 2);
	endtask : t_low_supply

	task automatic hreq(input logic rnd, input logic [6:0] a, input logic [7:0] c, input logic rdy);
		@(negedge sys_clk);
		{reqRandom, reqAddr, reqCount, rdReady, reqValid} = {rnd, a, c, rdy, 1'b1};
		@(negedge sys_clk);
		reqValid = 1'b0;
		check(reqReady, 1'b0);
	endtask : hreq
	task automatic hwait();
		for (int i = 0; i < 30000 && reqReady !== 1'b1; i++) @(negedge sys_clk);
		check(reqReady, 1'b1);
	endtask : hwait
	task automatic t_host_random();
		int base;
		base = popCnt;
		hreq(1'b1, 7'h10, 8'h00, 1'b1);
		hwait();
		check(popCnt - base, 1);
		check(nackErr, 1'b0);
	endtask : t_host_random
	task automatic t_host_fifo();
		int base;
		base = popCnt;
		hreq(1'b0, 7'h00, 8'h10, 1'b0);
		repeat (66000) @(negedge sys_clk);
		check(bus.sclLine, 1'b0);
		repeat (400) @(negedge sys_clk);
		check({reqReady, bus.sclLine, rdValid}, 3'h1);
		rdReady = 1'b1;
		hwait();
		check(popCnt - base, 17);
		check(rdValid, 1'b0);
	endtask : t_host_fifo

	initial begin
		#480000;
		failures++;
		end_of_test();
	end

	initial begin
		{rst_n, reqValid, reqRandom, rdReady, lowSupply, reqAddr, reqCount} = '0;
		{busB.hostSclOut, busB.hostSdaOut, busB.hostSclOe, busB.hostSdaOe} = 4'h0;
		repeat (2) @(posedge sys_clk);
		@(negedge sys_clk);
		rst_n = 1'b1;
		check({reqReady, rdValid, nackErr, writeBlocked, bus.sclLine, bus.sdaLine}, 6'h23);
		fork
			begin
				t_host_random();
				t_host_fifo();
			end
			begin
				#3;
				t_fill_read_all();
				t_current_read();
				t_low_supply();
			end
		join
		end_of_test();
	end
endmodule : serl_link_bench

`default_nettype wire
